// ---- rtl/evp_pkg.sv ----
// evp_pkg: constants shared by both ends of the exception vector decoder
// assumes a 16-bit vector address space, vector base in the upper byte
package evp_pkg;

  // number of ordinary maskable sources, base+0x82 .. base+0xF2
  localparam int EVP_NUM_IRQ = 57;
  localparam int EVP_IDX_W = 6;
  // the inter-die link source sits at the top slot, base+0xF2
  localparam logic [5:0] EVP_LINK_IDX = 6'h38;

  // vector base register
  localparam logic [7:0] EVP_VBR_RST = 8'hFF;
  localparam logic [7:0] EVP_DBG_BASE = 8'hFF;

  // fixed reset vectors
  localparam logic [15:0] EVP_VEC_RST_EXT = 16'hFFFE;
  localparam logic [15:0] EVP_VEC_RST_CLKMON = 16'hFFFC;
  localparam logic [15:0] EVP_VEC_RST_WDT = 16'hFFFA;

  // low-byte offsets from the vector base
  localparam logic [7:0] EVP_OFF_TRAP = 8'hF8;
  localparam logic [7:0] EVP_OFF_SWI = 8'hF6;
  localparam logic [7:0] EVP_OFF_XIRQ = 8'hF4;
  localparam logic [7:0] EVP_OFF_LINK = 8'hF2;
  localparam logic [7:0] EVP_OFF_IRQ_LO = 8'h82;
  localparam logic [7:0] EVP_OFF_SPUR = 8'h80;

  // depth of the saved-mask stack in the core end
  localparam int EVP_STK_DEPTH = 4;
  localparam int EVP_STK_W = 2;

  // low byte of the vector for ordinary source idx
  function automatic logic [7:0] evp_irq_off(input logic [5:0] idx);
    return EVP_OFF_IRQ_LO + 8'({idx, 1'b0});
  endfunction

  // join base and low byte into a vector address
  function automatic logic [15:0] evp_vec(input logic [7:0] base,
                                         input logic [7:0] off);
    return {base, off};
  endfunction

endpackage

// ---- rtl/evp_if.sv ----
// evp_if: link between the vector decoder and the cpu core end
// assumes both ends run on the same ref_clk
`timescale 1ns/1ps
interface evp_if;
  import evp_pkg::*;

  // core state seen by the decoder
  logic mask_i;
  logic mask_x;
  logic debug_active;
  logic trap_req;
  logic swi_req;
  // vector fetch
  logic vec_req;
  logic [15:0] vec_addr;
  logic vec_ack;
  logic vec_spur;
  logic int_pend;
  logic rst_pend;
  // vector base register access
  logic vbr_wr;
  logic [7:0] vbr_wdata;
  logic [7:0] vbr_rdata;

  modport dec (
    input mask_i, mask_x, debug_active, trap_req, swi_req, vec_req,
    input vbr_wr, vbr_wdata,
    output vec_addr, vec_ack, vec_spur, int_pend, rst_pend, vbr_rdata
  );

  modport cpu (
    output mask_i, mask_x, debug_active, trap_req, swi_req, vec_req,
    output vbr_wr, vbr_wdata,
    input vec_addr, vec_ack, vec_spur, int_pend, rst_pend, vbr_rdata
  );
endinterface

// ---- rtl/evp_prio_enc.sv ----
// evp_prio_enc: finds the highest-numbered active request line
// assumes index order equals vector order, higher index higher vector
`timescale 1ns/1ps
module evp_prio_enc (
  // requests
  input wire logic [evp_pkg::EVP_NUM_IRQ-1:0] req,
  // result
  output logic found,
  output logic [evp_pkg::EVP_IDX_W-1:0] idx
);
  import evp_pkg::*;

  // ascending scan, so the last hit is the highest vector
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = 0; i < EVP_NUM_IRQ; i++) begin
      if (req[i]) begin
        found = 1'b1;
        idx = 6'(i);
      end
    end
  end
endmodule // evp_prio_enc

// ---- rtl/evp_decoder.sv ----
// evp_decoder: exception priority decoder, device end of evp_if
// assumes peripherals and reset generator share ref_clk; the wake
// output is pure logic so it works with the clock stopped
//
// Function
// - unmaskable requests always outrank ordinary maskable ones
// - high-priority request preempts ordinary routine when unmasked
// - trap and software trap may nest
// - peripherals hold requests until routine starts
// - highest vector address wins among pending
// - ordinary request needs enable, clear mask, no higher
// - vector chosen at the moment it is asked
// - nothing pending gives spurious vector base+0x80
// - reset vectors first: 0xFFFE, 0xFFFC, 0xFFFA
// - then trap F8, software trap F6, high-priority F4
// - link at F2, others F0 down to 82
// - ordinary routines nest only after mask cleared
// - qualified ordinary request wakes; mask blocks wake
// - stop-mode wake path needs no clock
// - move the base register only when relocating table
// - vector base is register byte then 0x00
// - base register resets to 0xFF
// - background debug forces base byte to 0xFF
`timescale 1ns/1ps
module evp_decoder (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // link to the cpu core
  evp_if.dec cpu,
  // peripheral request lines and their local enables
  input wire logic [evp_pkg::EVP_NUM_IRQ-2:0] irq_req,
  input wire logic [evp_pkg::EVP_NUM_IRQ-2:0] irq_en,
  // inter-die link: normal and error requests
  input wire logic link_req,
  input wire logic link_en,
  input wire logic link_err_req,
  // reset causes from the reset generator
  input wire logic rst_ext_req,
  input wire logic rst_clkmon_req,
  input wire logic rst_wdt_req,
  // service notice back to the peripherals
  output logic svc_start,
  output logic [evp_pkg::EVP_IDX_W-1:0] svc_idx,
  // asynchronous wake-up for stop and wait
  output logic wake
);
  import evp_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // request qualification

  logic [EVP_NUM_IRQ-1:0] all_req;
  logic [EVP_NUM_IRQ-1:0] qual;
  logic irq_found;
  logic [EVP_IDX_W-1:0] irq_idx;
  logic x_pend;
  logic hi_pend;
  logic i_ok;
  logic any_rst;
  logic [7:0] base;
  logic [7:0] vbr_q;
  logic [7:0] vbr_d;

  // the link source takes the top slot, index 56
  assign all_req = {link_req & link_en, irq_req & irq_en};

  // raw requests are levels; the peripheral keeps them up until served
  assign qual = all_req;

  evp_prio_enc u_prio (
    .req(qual),
    .found(irq_found),
    .idx(irq_idx)
  );

  // high-priority request only sees its own mask, not the ordinary one
  assign x_pend = link_err_req & ~cpu.mask_x;

  // any request the ordinary mask cannot block
  assign hi_pend = cpu.trap_req | cpu.swi_req | x_pend;

  // ordinary request blocked by its mask or by a trap, software trap or high-priority request
  assign i_ok = irq_found & ~cpu.mask_i & ~hi_pend;

  assign any_rst = rst_ext_req | rst_clkmon_req | rst_wdt_req;

  // debug firmware keeps every vector in the top page
  always_comb begin
    if (cpu.debug_active) begin
      base = EVP_DBG_BASE;
    end else begin
      base = vbr_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // vector selection, continuous so it is ready on the request cycle

  logic [15:0] win_vec;
  logic win_spur;
  logic win_irq;

  always_comb begin
    win_spur = 1'b0;
    win_irq = 1'b0;
    if (rst_ext_req) begin
      win_vec = EVP_VEC_RST_EXT;
    end else if (rst_clkmon_req) begin
      win_vec = EVP_VEC_RST_CLKMON;
    end else if (rst_wdt_req) begin
      win_vec = EVP_VEC_RST_WDT;
    end else if (cpu.trap_req) begin
      win_vec = evp_vec(base, EVP_OFF_TRAP);
    end else if (cpu.swi_req) begin
      win_vec = evp_vec(base, EVP_OFF_SWI);
    end else if (x_pend) begin
      win_vec = evp_vec(base, EVP_OFF_XIRQ);
    end else if (i_ok) begin
      win_vec = evp_vec(base, evp_irq_off(irq_idx));
      win_irq = 1'b1;
    end else begin
      // request vanished between recognition and fetch
      win_vec = evp_vec(base, EVP_OFF_SPUR);
      win_spur = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // vector base register

  // software writes it only to move the table away from the top page
  always_comb begin
    vbr_d = vbr_q;
    if (cpu.vbr_wr) begin
      vbr_d = cpu.vbr_wdata;
    end
  end

  // reset loads the top page before any reset vector is fetched
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vbr_q <= EVP_VBR_RST;
    end else begin
      vbr_q <= vbr_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // vector answer and pending flags

  logic [15:0] vec_addr_q;
  logic [15:0] vec_addr_d;
  logic vec_ack_q;
  logic vec_ack_d;
  logic vec_spur_q;
  logic vec_spur_d;
  logic int_pend_q;
  logic int_pend_d;
  logic rst_pend_q;
  logic rst_pend_d;
  logic svc_start_q;
  logic svc_start_d;
  logic [EVP_IDX_W-1:0] svc_idx_q;
  logic [EVP_IDX_W-1:0] svc_idx_d;

  // winner is frozen on the request edge, not at recognition
  always_comb begin
    vec_addr_d = vec_addr_q;
    vec_spur_d = vec_spur_q;
    svc_idx_d = svc_idx_q;
    vec_ack_d = cpu.vec_req;
    svc_start_d = 1'b0;
    if (cpu.vec_req) begin
      vec_addr_d = win_vec;
      vec_spur_d = win_spur;
      svc_start_d = win_irq;
      if (win_irq) begin
        svc_idx_d = irq_idx;
      end
    end
    // recognised pending state, refreshed every cycle
    int_pend_d = any_rst | hi_pend | i_ok;
    rst_pend_d = any_rst;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_addr_q <= EVP_VEC_RST_EXT;
      vec_ack_q <= 1'b0;
      vec_spur_q <= 1'b0;
      int_pend_q <= 1'b0;
      rst_pend_q <= 1'b0;
      svc_start_q <= 1'b0;
      svc_idx_q <= '0;
    end else begin
      vec_addr_q <= vec_addr_d;
      vec_ack_q <= vec_ack_d;
      vec_spur_q <= vec_spur_d;
      int_pend_q <= int_pend_d;
      rst_pend_q <= rst_pend_d;
      svc_start_q <= svc_start_d;
      svc_idx_q <= svc_idx_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign cpu.vec_addr = vec_addr_q;
  assign cpu.vec_ack = vec_ack_q;
  assign cpu.vec_spur = vec_spur_q;
  assign cpu.int_pend = int_pend_q;
  assign cpu.rst_pend = rst_pend_q;
  assign cpu.vbr_rdata = vbr_q;
  assign svc_start = svc_start_q;
  assign svc_idx = svc_idx_q;

  // no flip-flop here: the clock is stopped in stop mode, so the
  // wake path must be gates from request level to output
  assign wake = ((|all_req) & ~cpu.mask_i) | x_pend;

endmodule // evp_decoder

// ---- rtl/evp_core_end.sv ----
// evp_core_end: cpu side of evp_if; holds the mask flags, issues
// vector fetches and keeps a small stack of saved masks for nesting
// assumes the core signals instruction events as one-cycle pulses
`timescale 1ns/1ps
module evp_core_end (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // link to the decoder
  evp_if.cpu dec,
  // instruction events from the core, one-cycle pulses
  input wire logic trap_exec,
  input wire logic swi_exec,
  input wire logic clear_mask_instruction,
  input wire logic clear_x_mask,
  input wire logic set_mask,
  input wire logic return_from_service,
  // background debug state
  input wire logic background_debug,
  // vector base register write
  input wire logic vbr_wr,
  input wire logic [7:0] vbr_wdata,
  // service entry seen by the core
  output logic svc_enter,
  output logic [15:0] svc_vec,
  output logic svc_spur,
  output logic mask_i,
  output logic mask_x
);
  import evp_pkg::*;

  typedef enum logic [0:0] {
    EVP_ST_RUN = 1'b0,
    EVP_ST_FETCH = 1'b1
  } evp_state_t;

  //////////////////////////////////////////////////////////////////////
  // state

  evp_state_t st_q, st_d;
  logic mask_i_q, mask_i_d, mask_x_q, mask_x_d;
  logic trap_q, trap_d, swi_q, swi_d;
  logic vreq_q, vreq_d;
  logic enter_q, enter_d;
  logic [15:0] vec_q, vec_d;
  logic spur_q, spur_d;
  logic dbg_q;
  logic [EVP_STK_W-1:0] sp_q, sp_d;
  logic [1:0] stk_q [EVP_STK_DEPTH];
  logic [1:0] stk_d [EVP_STK_DEPTH];
  logic [EVP_STK_W-1:0] top;

  assign top = sp_q - 2'(1);

  // fetch when something is recognised; masks settle on entry
  always_comb begin
    st_d = st_q;
    mask_i_d = mask_i_q;
    mask_x_d = mask_x_q;
    trap_d = trap_q | trap_exec;
    swi_d = swi_q | swi_exec;
    vreq_d = 1'b0;
    enter_d = 1'b0;
    vec_d = vec_q;
    spur_d = spur_q;
    sp_d = sp_q;
    stk_d = stk_q;
    if (clear_mask_instruction) begin
      mask_i_d = 1'b0;
    end
    if (set_mask) begin
      mask_i_d = 1'b1;
    end
    if (clear_x_mask) begin
      mask_x_d = 1'b0;
    end
    unique case (st_q)
      EVP_ST_RUN: begin
        // int_pend still shows the served request in the entry cycle
        if (dec.int_pend && !enter_q && !trap_exec && !swi_exec) begin
          vreq_d = 1'b1;
          st_d = EVP_ST_FETCH;
        end else if (return_from_service && sp_q != '0) begin
          {mask_x_d, mask_i_d} = stk_q[top];
          sp_d = top;
        end
      end
      EVP_ST_FETCH: begin
        if (dec.vec_ack) begin
          st_d = EVP_ST_RUN;
          enter_d = 1'b1;
          vec_d = dec.vec_addr;
          spur_d = dec.vec_spur;
          // save masks; a full stack keeps its oldest entries
          if (sp_q != 2'(EVP_STK_DEPTH - 1)) begin
            stk_d[sp_q] = {mask_x_q, mask_i_q};
            sp_d = sp_q + 2'(1);
          end
          // traps stay nestable: they ignore both masks
          // a trap raised in the ack cycle itself is kept, set wins
          if (dec.vec_addr[7:0] == EVP_OFF_TRAP) begin
            trap_d = trap_exec;
          end
          if (dec.vec_addr[7:0] == EVP_OFF_SWI) begin
            swi_d = swi_exec;
          end
          mask_i_d = 1'b1;
          if (dec.rst_pend || dec.vec_addr[7:0] == EVP_OFF_XIRQ) begin
            mask_x_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= EVP_ST_RUN;
      mask_i_q <= 1'b1;
      mask_x_q <= 1'b1;
      trap_q <= 1'b0;
      swi_q <= 1'b0;
      vreq_q <= 1'b0;
      enter_q <= 1'b0;
      vec_q <= '0;
      spur_q <= 1'b0;
      dbg_q <= 1'b0;
      sp_q <= '0;
      stk_q <= '{default: 2'h3};
    end else begin
      st_q <= st_d;
      mask_i_q <= mask_i_d;
      mask_x_q <= mask_x_d;
      trap_q <= trap_d;
      swi_q <= swi_d;
      vreq_q <= vreq_d;
      enter_q <= enter_d;
      vec_q <= vec_d;
      spur_q <= spur_d;
      dbg_q <= background_debug;
      sp_q <= sp_d;
      stk_q <= stk_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign dec.mask_i = mask_i_q;
  assign dec.mask_x = mask_x_q;
  assign dec.debug_active = dbg_q;
  assign dec.trap_req = trap_q;
  assign dec.swi_req = swi_q;
  assign dec.vec_req = vreq_q;
  // base register moved only when the table is relocated
  assign dec.vbr_wr = vbr_wr;
  assign dec.vbr_wdata = vbr_wdata;
  assign svc_enter = enter_q;
  assign svc_vec = vec_q;
  assign svc_spur = spur_q;
  assign mask_i = mask_i_q;
  assign mask_x = mask_x_q;

endmodule // evp_core_end

// ---- bench/evp_chk.sv ----
// evp_chk: assertions on the evp_if signals between decoder and core end
// assumes one clock ref_clk and asynchronous active-low rst_b
`timescale 1ns/1ps
module evp_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // core state and vector fetch
  input wire logic mask_i,
  input wire logic mask_x,
  input wire logic debug_active,
  input wire logic trap_req,
  input wire logic swi_req,
  input wire logic vec_req,
  input wire logic [15:0] vec_addr,
  input wire logic vec_ack,
  input wire logic vec_spur,
  input wire logic int_pend,
  input wire logic rst_pend,
  // base register access
  input wire logic vbr_wr,
  input wire logic [7:0] vbr_wdata,
  input wire logic [7:0] vbr_rdata
);
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // one fetch: request, then the answer a cycle later
  sequence s_fetch;
    vec_req ##1 vec_ack;
  endsequence
  // rst_pend lags its causes, so the vector-choice checks only run once it is low
  a_ack_after_req: assert property (vec_req |=> vec_ack)
    else $error("vector answer missing");
  a_ack_one_cycle: assert property (vec_ack |=> !vec_ack && !vec_req)
    else $error("answer or refetch too soon");
  a_mask_on_entry: assert property (s_fetch |=> mask_i)
    else $error("ordinary mask not set on entry");
  a_spur_addr: assert property (vec_ack && vec_spur |->
    vec_addr == {($past(debug_active) ? 8'hFF : $past(vbr_rdata)), 8'h80})
    else $error("spurious vector address wrong");
  a_trap_first: assert property (vec_req && trap_req && !rst_pend |=>
    vec_addr[7:0] == 8'hF8 && !vec_spur)
    else $error("trap vector not chosen");
  a_swi_next: assert property (vec_req && swi_req && !trap_req && !rst_pend |=>
    vec_addr[7:0] == 8'hF6)
    else $error("software trap vector not chosen");
  a_masked_spur: assert property (vec_req && mask_i && mask_x && !trap_req && !swi_req
    && !rst_pend |=> vec_spur)
    else $error("masked request delivered");
  a_vbr_write: assert property (vbr_wr |=> vbr_rdata == $past(vbr_wdata))
    else $error("base register write lost");
  a_addr_holds: assert property (!vec_ack |-> $stable(vec_addr))
    else $error("vector changed without answer");
  a_req_on_pend: assert property (vec_req |-> $past(int_pend))
    else $error("fetch without pending request");
endmodule // evp_chk

// ---- bench/testbench.sv ----
// testbench: both ends of evp_if joined, user sides driven by tasks
// assumes inputs change 2 ns after the rising edge of ref_clk
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench;
  import evp_pkg::*;
  logic ref_clk, rst_b, link_req, link_en, link_err_req, background_debug, vbr_wr;
  logic [55:0] irq_req, irq_en;
  logic [2:0] rst_req;
  logic [5:0] evs;
  logic [7:0] vbr_wdata;
  logic svc_enter, svc_start, svc_spur, mask_i, mask_x, wake;
  logic [15:0] svc_vec;
  logic [5:0] svc_idx;
  logic [5:0] seq_idx [3] = '{6'h38, 6'h28, 6'h03};
  int fails = 0;
  int tests_run = 0;
  ////////////////////////////////////////////////////////////////////////////////
  evp_if bus ();
  evp_decoder i_evp_decoder (.ref_clk(ref_clk), .rst_b(rst_b), .cpu(bus),
    .irq_req(irq_req), .irq_en(irq_en), .link_req(link_req), .link_en(link_en),
    .link_err_req(link_err_req), .rst_ext_req(rst_req[2]), .rst_clkmon_req(rst_req[1]),
    .rst_wdt_req(rst_req[0]), .svc_start(svc_start), .svc_idx(svc_idx), .wake(wake));
  evp_core_end i_evp_core_end (.ref_clk(ref_clk), .rst_b(rst_b), .dec(bus),
    .trap_exec(evs[0]), .swi_exec(evs[1]), .clear_mask_instruction(evs[2]),
    .clear_x_mask(evs[3]), .set_mask(evs[4]), .return_from_service(evs[5]),
    .background_debug(background_debug), .vbr_wr(vbr_wr), .vbr_wdata(vbr_wdata),
    .svc_enter(svc_enter), .svc_vec(svc_vec), .svc_spur(svc_spur),
    .mask_i(mask_i), .mask_x(mask_x));
  evp_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .mask_i(bus.mask_i),
    .mask_x(bus.mask_x), .debug_active(bus.debug_active), .trap_req(bus.trap_req),
    .swi_req(bus.swi_req), .vec_req(bus.vec_req), .vec_addr(bus.vec_addr),
    .vec_ack(bus.vec_ack), .vec_spur(bus.vec_spur), .int_pend(bus.int_pend),
    .rst_pend(bus.rst_pend), .vbr_wr(bus.vbr_wr), .vbr_wdata(bus.vbr_wdata),
    .vbr_rdata(bus.vbr_rdata));
  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // move n edges on, landing 2 ns past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // one-cycle instruction events
  task automatic pulse(input logic [5:0] m);
    evs = m;
    tick(1);
    evs = 6'h00;
  endtask
  // wait for the next service entry and compare its vector
  task automatic entry(input logic [15:0] v, input logic sp);
    int k;
    logic st;
    k = 0;
    st = 1'b0;
    tick(1);
    while (svc_enter !== 1'b1 && k < 200) begin
      st = st | svc_start;
      tick(1);
      k++;
    end
    if (k == 200) begin
      fails++;
      conclude();
    end
    `CHK("svc_vec", v, svc_vec)
    `CHK("svc_spur", sp, svc_spur)
    // only vectors of the ordinary range notify the peripherals
    `CHK("svc_start", !sp && v[7:0] >= 8'h82 && v[7:0] <= 8'hF2, st)
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {irq_req, link_req, link_err_req, rst_req, evs, background_debug, vbr_wr} = '0;
    irq_en = '1;
    link_en = 1'b1;
    vbr_wdata = 8'h00;
    rst_b = 1'b0;
    tick(16);
    rst_b = 1'b1;
    tick(1);
    `CHK("vbr_rst", 8'hFF, bus.vbr_rdata)
    `CHK("masks_rst", 2'b11, {mask_x, mask_i})
    // relocate the table; reset vectors must not follow
    vbr_wr = 1'b1;
    vbr_wdata = 8'h12;
    tick(1);
    vbr_wr = 1'b0;
    `CHK("vbr", 8'h12, bus.vbr_rdata)
    rst_req = 3'h7;
    entry(16'hFFFE, 1'b0);
    rst_req[2] = 1'b0;
    entry(16'hFFFC, 1'b0);
    rst_req[1] = 1'b0;
    entry(16'hFFFA, 1'b0);
    rst_req[0] = 1'b0;
    tick(6);
    // trap and software trap in the same cycle
    pulse(6'h03);
    entry(16'h12F8, 1'b0);
    entry(16'h12F6, 1'b0);
    tick(6);
    // request gone before the fetch
    pulse(6'h04);
    tick(2);
    irq_req[0] = 1'b1;
    tick(1);
    irq_req[0] = 1'b0;
    entry(16'h1280, 1'b1);
    tick(6);
    // three ordinary sources at once, served top down
    irq_req[3] = 1'b1;
    irq_req[40] = 1'b1;
    link_req = 1'b1;
    pulse(6'h04);
    for (int k = 0; k < 3; k++) begin
      entry({8'h12, 8'h82 + 8'(2 * seq_idx[k])}, 1'b0);
      `CHK("svc_idx", seq_idx[k], svc_idx)
      if (seq_idx[k] == 6'h38) link_req = 1'b0;
      else irq_req[seq_idx[k]] = 1'b0;
      tick(6);
      pulse(6'h04);
    end
    // high-priority request masked, then preempts an ordinary routine
    link_err_req = 1'b1;
    irq_req[5] = 1'b1;
    entry(16'h128C, 1'b0);
    irq_req[5] = 1'b0;
    tick(6);
    pulse(6'h08);
    entry(16'h12F4, 1'b0);
    link_err_req = 1'b0;
    tick(6);
    // wake follows mask and enable with no clock edge needed
    irq_req[7] = 1'b1;
    #1 `CHK("wake_masked", 1'b0, wake)
    tick(1);
    irq_en[7] = 1'b0;
    pulse(6'h04);
    `CHK("wake_disabled", 1'b0, wake)
    irq_en[7] = 1'b1;
    #1 `CHK("wake", 1'b1, wake)
    entry(16'h1290, 1'b0);
    irq_req[7] = 1'b0;
    tick(6);
    // debug forces the base; trap beats a pending ordinary source
    background_debug = 1'b1;
    irq_req[9] = 1'b1;
    tick(1);
    pulse(6'h05);
    entry(16'hFFF8, 1'b0);
    background_debug = 1'b0;
    tick(6);
    pulse(6'h04);
    entry(16'h1294, 1'b0);
    irq_req[9] = 1'b0;
    tick(6);
    // recognised while unmasked, masked again before the fetch
    irq_req[0] = 1'b1;
    pulse(6'h04);
    `CHK("mask_clr", 1'b0, mask_i)
    pulse(6'h14);
    `CHK("mask_set", 1'b1, mask_i)
    entry(16'h1280, 1'b1);
    irq_req[0] = 1'b0;
    tick(4);
    conclude();
  end
endmodule // testbench
